// ===== logic/hms_sequencer.sv
// Purpose: Measurement sequencing of a three-axis hall sensor
// Assumes: Bus engine outside delivers config strobe and bus idle
// Notes:   Converter is external; results queue in a FIFO
// Operation
// [RQ1] Start-up enables bias, then low power wait
// [RQ2] Reconfiguration starts one measurement cycle
// [RQ3] X, Y, Z through one mux, return
// [RQ4] Optional temperature conversion, default on
// [RQ5] Low supply halts; restart function from beginning
// [RQ6] Restart event abandons running measurement
// [RQ7] Open-drain completion interrupt on clock pin
// [RQ8] Target addresses 6A write, 6B read
// [RQ9] Axis results 12 bit, temperature 10
// [RQ10] Data line open-drain, never driven high
// [RQ11] Power-on reset, internal low-power clock
// [RQ12] Converter disabled while supply low
// [RQ13] Host issues bus reset if ramp unclean
// [RQ14] Interrupt fixed low pulse, bus idle only
`timescale 1ns/1ps
module hms_sequencer (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Supply monitor
	input  wire logic        supply_ok,
	// Configuration from bus engine
	input  wire logic        cfg_strobe,
	input  wire logic        cfg_temp_en,
	input  wire logic [6:0]  bus_addr,
	input  wire logic        bus_idle,
	// Analog controls
	output logic             bias_en,
	output logic             osc_fast_en,
	output logic             hall_bias_en,
	output logic             adc_en,
	output logic [1:0]       mux_sel,
	output logic             adc_start,
	input  wire logic        adc_done,
	input  wire logic [11:0] adc_data,
	// Result stream
	output logic [13:0]      res_data,
	output logic             res_valid,
	input  wire logic        res_ready,
	// Serial data pin drive
	input  wire logic        sda_tx_low,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             addr_match_wr,
	output logic             addr_match_rd,
	// Clock pin interrupt drive
	output logic             scl_int_o,
	output logic             scl_int_oe
);
	hms_pkg::hms_state_t state_reg;
	hms_pkg::hms_state_t state_next;
	logic [1:0]  ch_reg;
	logic        temp_en_reg;
	logic        pend_reg;
	logic [7:0]  cnt_reg;
	logic        busy_reg;
	logic [11:0] data_reg;
	logic        int_req_reg;
	logic [7:0]  int_cnt_reg;
	logic        fifo_ready;

	// Config latched each strobe; default keeps temperature on
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			temp_en_reg <= hms_pkg::TEMP_EN_RESET; // [RQ4]
		else if (cfg_strobe)
			temp_en_reg <= cfg_temp_en;
	end

	wire last_ch   = (ch_reg == hms_pkg::CH_Z && !temp_en_reg) || ch_reg == hms_pkg::CH_T; // [RQ4]
	wire bias_done = (cnt_reg == 8'(hms_pkg::BIAS_CYC - 1));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			hms_pkg::HMS_LOWPWR: if (pend_reg) state_next = hms_pkg::HMS_WAKE; // [RQ2]
			hms_pkg::HMS_WAKE:   if (supply_ok) state_next = hms_pkg::HMS_HBIAS; // [RQ5]
			hms_pkg::HMS_HBIAS:  if (bias_done) state_next = hms_pkg::HMS_CONV;
			hms_pkg::HMS_CONV:   if (adc_done) state_next = hms_pkg::HMS_STORE;
			hms_pkg::HMS_STORE:  if (fifo_ready) state_next = last_ch ? hms_pkg::HMS_DONE : hms_pkg::HMS_CONV; // [RQ3]
			hms_pkg::HMS_DONE:   state_next = hms_pkg::HMS_LOWPWR; // [RQ3]
			default:             state_next = hms_pkg::HMS_LOWPWR;
		endcase
	end

	// Supply loss abandons the cycle and restarts it from wake-up
	wire restart = !supply_ok && state_reg != hms_pkg::HMS_LOWPWR; // [RQ6]

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= hms_pkg::HMS_LOWPWR; // [RQ1] [RQ11]
			pend_reg  <= 1'b0;
		end else begin
			state_reg <= restart ? hms_pkg::HMS_WAKE : state_next; // [RQ5] [RQ6]
			// Strobe during a cycle queues another; set wins over clear
			pend_reg  <= cfg_strobe || (pend_reg && state_reg != hms_pkg::HMS_LOWPWR);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ch_reg   <= hms_pkg::CH_X;
			cnt_reg  <= 8'h00;
			busy_reg <= 1'b0;
			data_reg <= 12'h000;
		end else begin
			cnt_reg <= (state_reg == hms_pkg::HMS_HBIAS && !restart) ? cnt_reg + 8'h01 : 8'h00;
			if (restart || state_reg == hms_pkg::HMS_WAKE)
				ch_reg <= hms_pkg::CH_X; // [RQ5]
			else if (state_reg == hms_pkg::HMS_STORE && fifo_ready && !last_ch)
				ch_reg <= ch_reg + 2'h1; // [RQ3]
			busy_reg <= state_reg == hms_pkg::HMS_CONV && !adc_done && !restart;
			if (state_reg == hms_pkg::HMS_CONV && adc_done)
				data_reg <= adc_data;
		end
	end

	wire active = state_reg != hms_pkg::HMS_LOWPWR;
	assign bias_en      = 1'b1; // [RQ1]
	assign osc_fast_en  = active; // [RQ2]
	assign hall_bias_en = active && state_reg != hms_pkg::HMS_WAKE && supply_ok;
	assign adc_en       = hall_bias_en; // [RQ12]
	assign mux_sel      = ch_reg; // [RQ3]
	assign adc_start    = state_reg == hms_pkg::HMS_CONV && !busy_reg && supply_ok;

	// Tag bits let the reader tell the channel; temperature keeps 10 bits
	wire [11:0] store_val = (ch_reg == hms_pkg::CH_T) ? {2'h0, data_reg[11:2]} : data_reg; // [RQ9]
	hms_fifo #(.W(hms_pkg::FIFO_W), .D(hms_pkg::FIFO_D)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_data   ({ch_reg, store_val}),
		.in_valid  (state_reg == hms_pkg::HMS_STORE),
		.in_ready  (fifo_ready),
		.out_data  (res_data),
		.out_valid (res_valid),
		.out_ready (res_ready)
	);

	assign addr_match_wr = {bus_addr, 1'b0} == hms_pkg::ADDR_WRITE_BYTE; // [RQ8]
	assign addr_match_rd = {bus_addr, 1'b1} == hms_pkg::ADDR_READ_BYTE; // [RQ8]
	assign sda_o  = 1'b0; // [RQ10]
	assign sda_oe = sda_tx_low; // [RQ10]

	// Pulse waits for an idle bus so it never clips a clock phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_req_reg <= 1'b0;
			int_cnt_reg <= 8'h00;
		end else begin
			if (int_cnt_reg != 8'h00)
				int_cnt_reg <= int_cnt_reg - 8'h01;
			else if (int_req_reg && bus_idle)
				int_cnt_reg <= 8'(hms_pkg::INT_PULSE_CYC); // [RQ14]
			int_req_reg <= (state_reg == hms_pkg::HMS_DONE) ||
				(int_req_reg && !(int_cnt_reg == 8'h00 && bus_idle)); // [RQ7]
		end
	end
	assign scl_int_o  = 1'b0; // [RQ7]
	assign scl_int_oe = int_cnt_reg != 8'h00; // [RQ14]
endmodule // hms_sequencer

// ===== logic/hms_pkg.sv
// Purpose: Shared constants for the hall measurement sequencer
// Assumes: 10 MHz system clock
// Notes:   Step lengths are plain defaults
package hms_pkg;
	localparam int         CLK_HZ          = 10_000_000;
	localparam int         BIAS_TIME_NS    = 2000;
	localparam int         BIAS_CYC        = (BIAS_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int         INT_PULSE_NS    = 1000;
	localparam int         INT_PULSE_CYC   = (INT_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int         IDLE_CYC        = 4;
	localparam logic [6:0] ADDR_DEFAULT    = 7'h35;
	localparam logic [7:0] ADDR_WRITE_BYTE = 8'h6A;
	localparam logic [7:0] ADDR_READ_BYTE  = 8'h6B;
	localparam int         AXIS_W          = 12;
	localparam int         TEMP_W          = 10;
	localparam int         FIFO_W          = 14;
	localparam int         FIFO_D          = 16;
	localparam logic [1:0] CH_X            = 2'h0;
	localparam logic [1:0] CH_Y            = 2'h1;
	localparam logic [1:0] CH_Z            = 2'h2;
	localparam logic [1:0] CH_T            = 2'h3;
	localparam logic       TEMP_EN_RESET   = 1'b1;
	typedef enum logic [2:0] {HMS_LOWPWR, HMS_WAKE, HMS_HBIAS, HMS_CONV, HMS_STORE, HMS_DONE} hms_state_t;
endpackage

// ===== logic/hms_fifo.sv
// Purpose: Result FIFO between converter and bus read side
// Assumes: Single clock
// Notes:   Full and empty are exact
`timescale 1ns/1ps
module hms_fifo #(
	parameter int W = 14,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	// Fill side
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	// Drain side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp_reg;
	logic [AW:0]  rp_reg;
	wire          full  = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
	wire          empty = (wp_reg == rp_reg);
	wire          push  = in_valid && !full;
	wire          pop   = out_ready && !empty;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp_reg[AW-1:0]];
	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wp_reg[AW-1:0]] <= in_data;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			if (push)
				wp_reg <= wp_reg + 1'b1;
			if (pop)
				rp_reg <= rp_reg + 1'b1;
		end
	end
endmodule // hms_fifo

// ===== testbench/hms_assertions.sv
// Purpose: Port checks for the sequencer
// Assumes: One clock, async low reset
// Notes:   Bound to every sequencer
`timescale 1ns/1ps
module hms_assertions (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Inputs
	input wire logic        supply_ok,
	input wire logic        bus_idle,
	input wire logic        sda_tx_low,
	input wire logic        res_ready,
	input wire logic [6:0]  bus_addr,
	// Analog controls
	input wire logic        adc_en,
	input wire logic        hall_bias_en,
	input wire logic        adc_start,
	// Result stream
	input wire logic        res_valid,
	input wire logic [13:0] res_data,
	// Pin drives
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        addr_match_wr,
	input wire logic        addr_match_rd,
	input wire logic        scl_int_o,
	input wire logic        scl_int_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_sda_open_drain: assert property (!sda_o && sda_oe == sda_tx_low) else $error("sda drive");
	a_int_open_drain: assert property (!scl_int_o) else $error("int drive");
	a_int_pulse_len: assert property ($rose(scl_int_oe) |-> scl_int_oe[*8] ##1 scl_int_oe[*2] ##1 !scl_int_oe)
		else $error("int length");
	a_int_bus_idle: assert property ($rose(scl_int_oe) |-> $past(bus_idle)) else $error("int busy");
	a_addr_match: assert property (addr_match_wr == (bus_addr == 7'h35) && addr_match_rd == addr_match_wr)
		else $error("address");
	a_conv_supply: assert property (adc_en |-> supply_ok && hall_bias_en) else $error("adc en");
	a_low_halt: assert property (!supply_ok |=> !adc_start) else $error("halt");
	a_start_enabled: assert property (adc_start |-> adc_en) else $error("start off");
	a_head_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
		else $error("head");
	a_temp_width: assert property (res_valid && res_data[13:12] == 2'h3 |-> res_data[11:10] == 2'h0)
		else $error("temp");
endmodule // hms_assertions
bind hms_sequencer hms_assertions i_hms_assertions (
	.sys_clk       (sys_clk),
	.rst_n         (rst_n),
	.supply_ok     (supply_ok),
	.bus_idle      (bus_idle),
	.sda_tx_low    (sda_tx_low),
	.res_ready     (res_ready),
	.bus_addr      (bus_addr),
	.adc_en        (adc_en),
	.hall_bias_en  (hall_bias_en),
	.adc_start     (adc_start),
	.res_valid     (res_valid),
	.res_data      (res_data),
	.sda_o         (sda_o),
	.sda_oe        (sda_oe),
	.addr_match_wr (addr_match_wr),
	.addr_match_rd (addr_match_rd),
	.scl_int_o     (scl_int_o),
	.scl_int_oe    (scl_int_oe)
);

// ===== testbench/hms_adc_model.sv
// Purpose: Converter on the far side
// Assumes: Start level held until taken
// Notes:   Data line inverts between results
`timescale 1ns/1ps
module hms_adc_model (
	// Clock
	input wire logic       sys_clk,
	// Control from the sequencer
	input wire logic       adc_start,
	input wire logic [1:0] mux_sel,
	input wire logic [3:0] lat,
	// Result
	output logic           adc_done = 1'b0,
	output logic [11:0]    adc_data = 12'h000
);
	logic [3:0] cnt = 4'h0;
	always @(posedge sys_clk) begin
		adc_done <= cnt == 4'h1;
		adc_data <= cnt == 4'h1 ? {mux_sel, 10'h1A5} : ~adc_data;
		cnt <= cnt > 4'h1 ? cnt - 4'h1 : (adc_start && cnt == 4'h0 ? lat : 4'h0);
	end
endmodule // hms_adc_model

// ===== testbench/hms_sequencer_tb.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: 10 MHz clock, converter model
// Notes:   Fills the FIFO, brown-out mid-cycle
`timescale 1ns/1ps
module hms_sequencer_tb;
	logic sys_clk = 0, rst_n = 0, supply_ok = 1, cfg_strobe = 0, cfg_temp_en = 1, bus_idle = 1;
	logic res_ready = 0, sda_tx_low = 0, adc_done, adc_start, bias_en, osc_fast_en, hall_bias_en, adc_en;
	logic sda_o, sda_oe, addr_match_wr, addr_match_rd, scl_int_o, scl_int_oe, res_valid;
	logic [6:0] bus_addr = 7'h35;
	logic [1:0] mux_sel;
	logic [11:0] adc_data;
	logic [13:0] res_data;
	logic [3:0] lat = 4'h2;
	int fail_count = 0, check_count = 0, i;
	initial forever #50 sys_clk = ~sys_clk;
	hms_sequencer i_hms_sequencer (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.supply_ok     (supply_ok),
		.cfg_strobe    (cfg_strobe),
		.cfg_temp_en   (cfg_temp_en),
		.bus_addr      (bus_addr),
		.bus_idle      (bus_idle),
		.bias_en       (bias_en),
		.osc_fast_en   (osc_fast_en),
		.hall_bias_en  (hall_bias_en),
		.adc_en        (adc_en),
		.mux_sel       (mux_sel),
		.adc_start     (adc_start),
		.adc_done      (adc_done),
		.adc_data      (adc_data),
		.res_data      (res_data),
		.res_valid     (res_valid),
		.res_ready     (res_ready),
		.sda_tx_low    (sda_tx_low),
		.sda_o         (sda_o),
		.sda_oe        (sda_oe),
		.addr_match_wr (addr_match_wr),
		.addr_match_rd (addr_match_rd),
		.scl_int_o     (scl_int_o),
		.scl_int_oe    (scl_int_oe)
	);
	hms_adc_model i_hms_adc_model (
		.sys_clk   (sys_clk),
		.adc_start (adc_start),
		.mux_sel   (mux_sel),
		.lat       (lat),
		.adc_done  (adc_done),
		.adc_data  (adc_data)
	);
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [13:0] got, exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Bounded so a stuck design ends the run
	task automatic wait_hi(ref logic s);
		int k;
		for (k = 0; k < 600 && s !== 1'b1; k++) tick(1);
		if (k == 600) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, s, 1'b1);
			give_verdict();
		end
	endtask
	task automatic strobe(input logic t);
		cfg_temp_en = t;
		cfg_strobe = 1'b1;
		tick(1);
		cfg_strobe = 1'b0;
	endtask
	task automatic pop(input logic [1:0] ch);
		logic [11:0] d;
		d = {ch, 10'h1A5};
		wait_hi(res_valid);
		chk(res_data, ch == 2'h3 ? {ch, 2'h0, d[11:2]} : {ch, d});
		res_ready = 1'b1;
		tick(1);
		res_ready = 1'b0;
		tick(1);
	endtask
	task automatic t_pins;
		chk({osc_fast_en, res_valid, scl_int_oe, bias_en}, 4'h1);
		sda_tx_low = 1'b1;
		tick(1);
		chk({sda_oe, sda_o, addr_match_wr, addr_match_rd}, 4'hB);
		bus_addr = 7'h34;
		sda_tx_low = 1'b0;
		tick(1);
		chk({sda_oe, addr_match_wr, addr_match_rd}, 3'h0);
		bus_addr = 7'h35;
		$display("pins done");
	endtask
	// Fifth cycle starts on the full FIFO; draining begins before its first store
	task automatic t_fill;
		for (i = 0; i < 5; i++) begin
			strobe(1'b1);
			if (i < 4) wait_hi(scl_int_oe);
			tick(20);
		end
		for (i = 0; i < 20; i++) pop(i[1:0]);
		tick(30);
		chk(res_valid, 1'b0);
		$display("fill done");
	endtask
	task automatic t_notemp;
		bus_idle = 1'b0;
		strobe(1'b0);
		tick(80);
		chk(scl_int_oe, 1'b0);
		bus_idle = 1'b1;
		wait_hi(scl_int_oe);
		for (i = 0; i < 3; i++) pop(i[1:0]);
		chk(res_valid, 1'b0);
		$display("no temp done");
	endtask
	task automatic t_brown;
		lat = 4'h9;
		strobe(1'b1);
		wait_hi(adc_start);
		chk({osc_fast_en, hall_bias_en, adc_en, mux_sel}, 5'h1C);
		supply_ok = 1'b0;
		tick(3);
		chk({adc_en, hall_bias_en, res_valid}, 3'h0);
		supply_ok = 1'b1;
		wait_hi(scl_int_oe);
		for (i = 0; i < 4; i++) pop(i[1:0]);
		chk(res_valid, 1'b0);
		$display("brown-out done");
	endtask
	// Reset lands during the Y conversion with X already queued
	task automatic t_reset;
		strobe(1'b1);
		tick(40);
		chk({osc_fast_en, res_valid}, 2'h3);
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		chk({osc_fast_en, hall_bias_en, res_valid, scl_int_oe}, 4'h0);
		strobe(1'b1);
		wait_hi(scl_int_oe);
		for (i = 0; i < 4; i++) pop(i[1:0]);
		chk(res_valid, 1'b0);
		$display("reset done");
	endtask
	initial begin
		tick(12);
		rst_n = 1'b1;
		t_pins();
		t_fill();
		t_notemp();
		t_brown();
		t_reset();
		give_verdict();
	end
endmodule // hms_sequencer_tb
